// ==== hdl/trcd_top.sv ====
// Function
// - mode zero: terminals one, two generic
// - nonzero mode overrides terminal one, two codes
// - mode 1: one forward, two reverse
// - mode 2: one run, two direction
// - three-wire: one starts, three stops, two direction
// - three-wire: terminal three code ignored
// - modes 4-6 decode like 1-3
// - quick start keeps output stage ready
// - codes reset to 1,2,3,4 and 0
// - terminal seven code zero is pulse input
// - codes 1-4 give 4-bit preset selector
// - master plus presets gives 16 steps
// - code 5 issues fault reset
// - codes 11, 12, 40 block, pause, coast
// - block or pause cuts output, then restart
// - codes 19,20 up/down; 15,16 source force
// - code 22 clears counter, 23 counts on terminal six only
// - codes 83,84 motor, 51,52 sequencer bits
// - code 38 locks nonvolatile writes
// - code 28 emergency stop, 18 ramp stop
`timescale 1ns/100ps
module trcd_top
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [6:0]  terminal_closed,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             forward_run,
    output logic             reverse_run,
    output logic             output_ready,
    output logic             output_cut,
    output logic             coast_stop,
    output logic             ramp_stop,
    output logic             emergency_stop_fault,
    output logic             fault_reset,
    output logic             inch_run,
    output logic             inch_fwd,
    output logic             inch_rev,
    output logic [3:0]       speed_select,
    output logic             freq_up,
    output logic             freq_down,
    output logic             src_voltage_analog_input,
    output logic             src_current_analog_input,
    output logic             counter_clear,
    output logic             counter_count,
    output logic [1:0]       motor_select,
    output logic [1:0]       sequencer_select,
    output logic             nvm_write_lock,
    output logic             pulse_input_en,
    output logic             pulse_level
);

    trcd_if syncd ();

    logic [2:0]  wiring_mode_setting;
    logic [48:0] codes;
    logic [31:0] func_on;
    logic [6:0]  skip_mask;
    logic [31:0] rd_data;
    logic [31:0] status;
    logic        wr_hit;
    logic        three_wire;
    logic        run_cmd;
    logic [2:0]  base_mode;
    logic [6:0]  c;

    logic [2:0]  next_mode;
    logic [48:0] next_codes;
    logic [31:0] next_dat;
    logic        next_ack;
    trcd_pkg::trcd_run_e run_st;
    trcd_pkg::trcd_run_e next_run_st;
    logic        next_fwd;
    logic        next_rev;
    logic        next_rdy;
    logic        next_cut;
    logic        next_pulse_en;

    // map a quick start mode onto its plain counterpart
    function automatic logic [2:0] plain_mode(input logic [2:0] m);
        if (m > trcd_pkg::MODE_3W && m <= trcd_pkg::MODE_3W_QS)
            plain_mode = m - trcd_pkg::QS_OFFSET;
        else
            plain_mode = m;
    endfunction

    function automatic logic is_quick(input logic [2:0] m);
        is_quick = (m >= trcd_pkg::MODE_2W1_QS)
                && (m <= trcd_pkg::MODE_3W_QS);
    endfunction

    trcd_sync u_sync
    (
        .clk             (clk),
        .reset           (reset),
        .terminal_closed (terminal_closed),
        .sync_out        (syncd.producer)
    );

    trcd_funcs u_funcs
    (
        .clk       (clk),
        .reset     (reset),
        .contacts  (syncd.consumer),
        .codes     (codes),
        .skip_mask (skip_mask),
        .func_on   (func_on)
    );

    assign c          = syncd.contact;
    assign base_mode  = plain_mode(wiring_mode_setting);
    assign three_wire = (base_mode == trcd_pkg::MODE_3W);

    // terminals whose own codes are disregarded
    always_comb
    begin
        skip_mask = 7'h00;
        if (wiring_mode_setting != trcd_pkg::MODE_NONE)
        begin
            skip_mask[trcd_pkg::T_ONE] = 1'b1;
            skip_mask[trcd_pkg::T_TWO] = 1'b1;
        end
        if (three_wire)
        begin
            skip_mask[trcd_pkg::T_THREE] = 1'b1;
        end
        if (codes[trcd_pkg::T_SEVEN*7 +: 7] == trcd_pkg::FN_NONE)
        begin
            skip_mask[trcd_pkg::T_SEVEN] = 1'b1;
        end
    end

    // a write lands on the edge at which ack is sampled high
    assign wr_hit = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

    // next values of the setting registers
    always_comb
    begin
        next_mode  = wiring_mode_setting;
        next_codes = codes;
        if (wr_hit)
        begin
            case (wb_adr_i)
                trcd_pkg::REG_MODE:
                begin
                    next_mode = wb_dat_i[trcd_pkg::MODE_W-1:0];
                end
                trcd_pkg::REG_FN_LO:
                begin
                    next_codes[trcd_pkg::LO_BITS-1:0] =
                        wb_dat_i[trcd_pkg::LO_BITS-1:0];
                end
                trcd_pkg::REG_FN_HI:
                begin
                    next_codes[trcd_pkg::LO_BITS +: trcd_pkg::HI_BITS] =
                        wb_dat_i[trcd_pkg::HI_BITS-1:0];
                end
                default:
                begin
                    next_mode = wiring_mode_setting;
                end
            endcase
        end
    end

    // status word seen by software
    always_comb
    begin
        status = 32'h0000_0000;
        status[trcd_pkg::ST_FWD]   = forward_run;
        status[trcd_pkg::ST_REV]   = reverse_run;
        status[trcd_pkg::ST_RDY]   = output_ready;
        status[trcd_pkg::ST_BLOCK] = output_cut;
        status[trcd_pkg::ST_SEL +: trcd_pkg::SEL_W] = speed_select;
    end

    // read data for the addressed register, zero elsewhere
    always_comb
    begin
        case (wb_adr_i)
            trcd_pkg::REG_MODE:
                rd_data = 32'(wiring_mode_setting);
            trcd_pkg::REG_FN_LO:
                rd_data = 32'(codes[trcd_pkg::LO_BITS-1:0]);
            trcd_pkg::REG_FN_HI:
                rd_data = 32'(codes >> trcd_pkg::LO_BITS);
            trcd_pkg::REG_STATUS:
                rd_data = status;
            trcd_pkg::REG_AUX:
                rd_data = func_on;
            trcd_pkg::REG_TERMS:
                rd_data = 32'(c);
            default:
                rd_data = 32'h0000_0000;
        endcase
    end

    // answer one cycle after the request; ack stands one cycle only,
    // so a held request is answered again every second cycle
    always_comb
    begin
        next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
        next_dat = next_ack ? rd_data : 32'h0000_0000;
    end

    // three-wire run latch: an open stop contact always wins
    always_comb
    begin
        next_run_st = run_st;
        if (!three_wire || !c[trcd_pkg::T_THREE])
        begin
            next_run_st = trcd_pkg::TRCD_IDLE;
        end
        else if (c[trcd_pkg::T_ONE])
        begin
            next_run_st = trcd_pkg::TRCD_RUN;
        end
        run_cmd = (next_run_st == trcd_pkg::TRCD_RUN);
    end

    // roles of terminals one and two for each wiring mode
    always_comb
    begin
        next_fwd = 1'b0;
        next_rev = 1'b0;
        case (base_mode)
            trcd_pkg::MODE_2W1:
            begin
                next_fwd = c[trcd_pkg::T_ONE];
                next_rev = c[trcd_pkg::T_TWO];
            end
            trcd_pkg::MODE_2W2:
            begin
                next_fwd = c[trcd_pkg::T_ONE] && !c[trcd_pkg::T_TWO];
                next_rev = c[trcd_pkg::T_ONE] && c[trcd_pkg::T_TWO];
            end
            trcd_pkg::MODE_3W:
            begin
                next_fwd = run_cmd && !c[trcd_pkg::T_TWO];
                next_rev = run_cmd && c[trcd_pkg::T_TWO];
            end
            default:
            begin
                next_fwd = 1'b0;
                next_rev = 1'b0;
            end
        endcase
    end

    // output stage: cut by block or pause, kept ready in quick start;
    // the run command is kept, so a released pause restarts the motor
    always_comb
    begin
        next_cut = func_on[trcd_pkg::SL_BBLK]
                || func_on[trcd_pkg::SL_PAUSE];
        next_rdy = is_quick(wiring_mode_setting)
                || ((next_fwd || next_rev) && !next_cut);
        next_pulse_en = (codes[trcd_pkg::T_SEVEN*trcd_pkg::CODE_W +:
                         trcd_pkg::CODE_W] == trcd_pkg::FN_NONE);
    end

    // every register of the top level
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wiring_mode_setting <= trcd_pkg::MODE_RESET;
            codes               <= {trcd_pkg::FN_RST_T7,
                                    trcd_pkg::FN_RST_T6,
                                    trcd_pkg::FN_RST_T5,
                                    trcd_pkg::FN_RST_T4,
                                    trcd_pkg::FN_RST_T3,
                                    trcd_pkg::FN_RST_T2,
                                    trcd_pkg::FN_RST_T1};
            wb_ack_o            <= 1'b0;
            wb_dat_o            <= 32'h0000_0000;
            run_st              <= trcd_pkg::TRCD_IDLE;
            forward_run         <= 1'b0;
            reverse_run         <= 1'b0;
            output_ready        <= 1'b0;
            output_cut          <= 1'b0;
            pulse_input_en      <= 1'b0;
        end
        else
        begin
            wiring_mode_setting <= next_mode;
            codes               <= next_codes;
            wb_ack_o            <= next_ack;
            wb_dat_o            <= next_dat;
            run_st              <= next_run_st;
            forward_run         <= next_fwd;
            reverse_run         <= next_rev;
            output_ready        <= next_rdy;
            output_cut          <= next_cut;
            pulse_input_en      <= next_pulse_en;
        end
    end

    // preset selector, zero keeps the master speed
    assign speed_select = {func_on[trcd_pkg::SL_SPD4],
                           func_on[trcd_pkg::SL_SPD3],
                           func_on[trcd_pkg::SL_SPD2],
                           func_on[trcd_pkg::SL_SPD1]};

    // stop and fault requests
    assign coast_stop           = func_on[trcd_pkg::SL_COAST];
    assign ramp_stop            = func_on[trcd_pkg::SL_RAMP];
    assign emergency_stop_fault = func_on[trcd_pkg::SL_ESTOP];
    assign fault_reset          = func_on[trcd_pkg::SL_FRST];

    // inch requests
    assign inch_run = func_on[trcd_pkg::SL_INCH];
    assign inch_fwd = func_on[trcd_pkg::SL_IFWD];
    assign inch_rev = func_on[trcd_pkg::SL_IREV];

    // frequency steps and forced speed source
    assign freq_up                  = func_on[trcd_pkg::SL_UP];
    assign freq_down                = func_on[trcd_pkg::SL_DOWN];
    assign src_voltage_analog_input = func_on[trcd_pkg::SL_VOLT];
    assign src_current_analog_input = func_on[trcd_pkg::SL_CURR];

    // counter controls
    assign counter_clear = func_on[trcd_pkg::SL_CCLR];
    assign counter_count = func_on[trcd_pkg::SL_CCNT];

    // motor and sequencer selection bits
    assign motor_select     = {func_on[trcd_pkg::SL_MOT1],
                               func_on[trcd_pkg::SL_MOT0]};
    assign sequencer_select = {func_on[trcd_pkg::SL_SEQ1],
                               func_on[trcd_pkg::SL_SEQ0]};

    // nonvolatile write lock
    assign nvm_write_lock = func_on[trcd_pkg::SL_LOCK];

    // terminal seven level for the pulse path
    assign pulse_level = c[trcd_pkg::T_SEVEN];

endmodule

// ==== hdl/trcd_pkg.sv ====
package trcd_pkg;

    // wiring modes
    localparam logic [2:0] MODE_NONE     = 3'h0;
    localparam logic [2:0] MODE_2W1      = 3'h1;
    localparam logic [2:0] MODE_2W2      = 3'h2;
    localparam logic [2:0] MODE_3W       = 3'h3;
    localparam logic [2:0] MODE_2W1_QS   = 3'h4;
    localparam logic [2:0] MODE_2W2_QS   = 3'h5;
    localparam logic [2:0] MODE_3W_QS    = 3'h6;
    localparam logic [2:0] MODE_RESET    = 3'h1;
    localparam logic [2:0] QS_OFFSET     = 3'h3;

    // terminal function codes
    localparam logic [6:0] FN_NONE       = 7'h00;
    localparam logic [6:0] FN_SPEED1     = 7'h01;
    localparam logic [6:0] FN_SPEED2     = 7'h02;
    localparam logic [6:0] FN_SPEED3     = 7'h03;
    localparam logic [6:0] FN_SPEED4     = 7'h04;
    localparam logic [6:0] FN_FAULT_RST  = 7'h05;
    localparam logic [6:0] FN_INCH       = 7'h06;
    localparam logic [6:0] FN_BASE_BLOCK = 7'h0B;
    localparam logic [6:0] FN_OUT_PAUSE  = 7'h0C;
    localparam logic [6:0] FN_SRC_VOLT   = 7'h0F;
    localparam logic [6:0] FN_SRC_CURR   = 7'h10;
    localparam logic [6:0] FN_RAMP_STOP  = 7'h12;
    localparam logic [6:0] FN_FREQ_UP    = 7'h13;
    localparam logic [6:0] FN_FREQ_DOWN  = 7'h14;
    localparam logic [6:0] FN_CNT_CLEAR  = 7'h16;
    localparam logic [6:0] FN_CNT_INPUT  = 7'h17;
    localparam logic [6:0] FN_INCH_FWD   = 7'h18;
    localparam logic [6:0] FN_INCH_REV   = 7'h19;
    localparam logic [6:0] FN_ESTOP      = 7'h1C;
    localparam logic [6:0] FN_NVM_LOCK   = 7'h26;
    localparam logic [6:0] FN_COAST      = 7'h28;
    localparam logic [6:0] FN_SEQ_B0     = 7'h33;
    localparam logic [6:0] FN_SEQ_B1     = 7'h34;
    localparam logic [6:0] FN_MOTOR_B0   = 7'h53;
    localparam logic [6:0] FN_MOTOR_B1   = 7'h54;

    // function code reset values for terminals one to seven
    localparam logic [6:0] FN_RST_T1     = 7'h00;
    localparam logic [6:0] FN_RST_T2     = 7'h00;
    localparam logic [6:0] FN_RST_T3     = 7'h01;
    localparam logic [6:0] FN_RST_T4     = 7'h02;
    localparam logic [6:0] FN_RST_T5     = 7'h03;
    localparam logic [6:0] FN_RST_T6     = 7'h04;
    localparam logic [6:0] FN_RST_T7     = 7'h00;

    // terminal indices
    localparam int T_ONE   = 0;
    localparam int T_TWO   = 1;
    localparam int T_THREE = 2;
    localparam int T_SIX   = 5;
    localparam int T_SEVEN = 6;
    localparam int N_TERM  = 7;
    localparam int CODE_W  = 7;

    // bit positions of each function in the decoded vector
    localparam int SL_SPD1   = 1;
    localparam int SL_SPD2   = 2;
    localparam int SL_SPD3   = 3;
    localparam int SL_SPD4   = 4;
    localparam int SL_FRST   = 5;
    localparam int SL_INCH   = 6;
    localparam int SL_BBLK   = 7;
    localparam int SL_PAUSE  = 8;
    localparam int SL_VOLT   = 9;
    localparam int SL_CURR   = 10;
    localparam int SL_RAMP   = 11;
    localparam int SL_UP     = 12;
    localparam int SL_DOWN   = 13;
    localparam int SL_CCLR   = 14;
    localparam int SL_CCNT   = 15;
    localparam int SL_IFWD   = 16;
    localparam int SL_IREV   = 17;
    localparam int SL_ESTOP  = 18;
    localparam int SL_LOCK   = 19;
    localparam int SL_COAST  = 20;
    localparam int SL_SEQ0   = 21;
    localparam int SL_SEQ1   = 22;
    localparam int SL_MOT0   = 23;
    localparam int SL_MOT1   = 24;

    // code register split: terminals one to four low, five to seven high
    localparam int LO_BITS   = 28;
    localparam int HI_BITS   = 21;
    localparam int SEL_W     = 4;
    localparam int MODE_W    = 3;

    // wishbone register byte offsets
    localparam logic [7:0] REG_MODE      = 8'h00;
    localparam logic [7:0] REG_FN_LO     = 8'h04;
    localparam logic [7:0] REG_FN_HI     = 8'h08;
    localparam logic [7:0] REG_STATUS    = 8'h0C;
    localparam logic [7:0] REG_AUX       = 8'h10;
    localparam logic [7:0] REG_TERMS     = 8'h14;

    // status register layout
    localparam int ST_FWD    = 0;
    localparam int ST_REV    = 1;
    localparam int ST_RDY    = 2;
    localparam int ST_BLOCK  = 3;
    localparam int ST_SEL    = 4;

    // three-wire run latch states
    typedef enum logic [0:0] { TRCD_IDLE, TRCD_RUN } trcd_run_e;

endpackage

// ==== hdl/trcd_if.sv ====
`timescale 1ns/100ps
// synchronised contact levels travelling to the decoder
interface trcd_if;
    logic [6:0] contact;
    modport producer (output contact);
    modport consumer (input  contact);
endinterface

// ==== hdl/trcd_sync.sv ====
`timescale 1ns/100ps
module trcd_sync
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [6:0] terminal_closed,
    trcd_if.producer        sync_out
);

    logic [6:0] stage1;
    logic [6:0] stage2;
    logic [6:0] next_stage1;
    logic [6:0] next_stage2;

    // two flop chain per contact, closed to common reads as one
    always_comb
    begin
        next_stage1 = terminal_closed;
        next_stage2 = stage1;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            stage1 <= 7'h00;
            stage2 <= 7'h00;
        end
        else
        begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign sync_out.contact = stage2;

endmodule

// ==== hdl/trcd_funcs.sv ====
`timescale 1ns/100ps
module trcd_funcs
(
    input  wire logic        clk,
    input  wire logic        reset,
    trcd_if.consumer         contacts,
    input  wire logic [48:0] codes,
    input  wire logic [6:0]  skip_mask,
    output logic      [31:0] func_on
);

    logic [31:0] next_func_on;
    logic [31:0] acc;

    // binary bit index of a known code, zero for an unknown one
    function automatic logic [4:0] fn_slot(input logic [6:0] c);
        case (c)
            trcd_pkg::FN_SPEED1:     fn_slot = 5'h01;
            trcd_pkg::FN_SPEED2:     fn_slot = 5'h02;
            trcd_pkg::FN_SPEED3:     fn_slot = 5'h03;
            trcd_pkg::FN_SPEED4:     fn_slot = 5'h04;
            trcd_pkg::FN_FAULT_RST:  fn_slot = 5'h05;
            trcd_pkg::FN_INCH:       fn_slot = 5'h06;
            trcd_pkg::FN_BASE_BLOCK: fn_slot = 5'h07;
            trcd_pkg::FN_OUT_PAUSE:  fn_slot = 5'h08;
            trcd_pkg::FN_SRC_VOLT:   fn_slot = 5'h09;
            trcd_pkg::FN_SRC_CURR:   fn_slot = 5'h0A;
            trcd_pkg::FN_RAMP_STOP:  fn_slot = 5'h0B;
            trcd_pkg::FN_FREQ_UP:    fn_slot = 5'h0C;
            trcd_pkg::FN_FREQ_DOWN:  fn_slot = 5'h0D;
            trcd_pkg::FN_CNT_CLEAR:  fn_slot = 5'h0E;
            trcd_pkg::FN_CNT_INPUT:  fn_slot = 5'h0F;
            trcd_pkg::FN_INCH_FWD:   fn_slot = 5'h10;
            trcd_pkg::FN_INCH_REV:   fn_slot = 5'h11;
            trcd_pkg::FN_ESTOP:      fn_slot = 5'h12;
            trcd_pkg::FN_NVM_LOCK:   fn_slot = 5'h13;
            trcd_pkg::FN_COAST:      fn_slot = 5'h14;
            trcd_pkg::FN_SEQ_B0:     fn_slot = 5'h15;
            trcd_pkg::FN_SEQ_B1:     fn_slot = 5'h16;
            trcd_pkg::FN_MOTOR_B0:   fn_slot = 5'h17;
            trcd_pkg::FN_MOTOR_B1:   fn_slot = 5'h18;
            default:                 fn_slot = 5'h00;
        endcase
    endfunction

    // or together every closed terminal not set in skip_mask into its function slot
    always_comb
    begin
        acc = 32'h0000_0000;
        for (int i = 0; i < trcd_pkg::N_TERM; i++)
        begin
            if (contacts.contact[i] && !skip_mask[i])
            begin
                acc[fn_slot(codes[i*7 +: 7])] = 1'b1;
            end
        end
        // counter input is only wired on terminal six
        if (codes[trcd_pkg::T_SIX*7 +: 7] != trcd_pkg::FN_CNT_INPUT)
        begin
            acc[5'h0F] = 1'b0;
        end
        else
        begin
            acc[5'h0F] = contacts.contact[trcd_pkg::T_SIX];
        end
        acc[0] = 1'b0;
        next_func_on = acc;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            func_on <= 32'h0000_0000;
        end
        else
        begin
            func_on <= next_func_on;
        end
    end

endmodule

// ==== testbench/trcd_props.sv ====
`timescale 1ns/100ps
module trcd_props
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [6:0]  terminal_closed,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic        wb_ack_o,
    input wire logic        forward_run,
    input wire logic        reverse_run,
    input wire logic        output_ready,
    input wire logic [3:0]  speed_select,
    input wire logic        pulse_input_en,
    input wire logic        pulse_level
);
    logic [2:0] mode;
    logic [2:0] next_mode;
    logic       wr;
    logic [6:0] tc;
    // shadow of the wiring mode written over the bus
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign tc = terminal_closed;
    always_comb
    begin
        next_mode = mode;
        if (wr && wb_adr_i == trcd_pkg::REG_MODE)
            next_mode = wb_dat_i[2:0];
    end
    always_ff @(posedge clk)
        mode <= reset ? trcd_pkg::MODE_RESET : next_mode;

    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // bus idle and contacts steady long enough to settle
    sequence quiet;
        (!wb_cyc_i && $stable(tc))[*6];
    endsequence

    ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    ack_held_a: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
        else $error("ack without request");
    settle_out_a: assert property (quiet |->
        $stable({forward_run, reverse_run, speed_select, pulse_level}))
        else $error("outputs moved on steady contacts");
    qs_ready_a: assert property (quiet ##0 mode > 3'h3 |-> output_ready)
        else $error("quick start not ready");
    mode0_idle_a: assert property (quiet ##0 mode == 3'h0
        |-> !forward_run && !reverse_run) else $error("mode 0 runs");
    two_wire_a: assert property (quiet ##0 (mode == 3'h1 ||
        mode == 3'h4) |-> forward_run == tc[0] && reverse_run == tc[1])
        else $error("two wire mode 1 decode");
    run_dir_a: assert property (quiet ##0 (mode == 3'h2 ||
        mode == 3'h5) |-> (forward_run || reverse_run) == tc[0]
        && (!tc[0] || reverse_run == tc[1])) else $error("run dir decode");
    three_stop_a: assert property (quiet ##0 (mode == 3'h3 ||
        mode == 3'h6) && !tc[2] |-> !forward_run && !reverse_run)
        else $error("three wire stop");
    pulse_lvl_a: assert property (quiet ##0 pulse_input_en
        |-> pulse_level == tc[6]) else $error("pulse level");
endmodule

bind trcd_top trcd_props trcd_props_inst (.clk, .reset, .terminal_closed,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o,
    .forward_run, .reverse_run, .output_ready, .speed_select,
    .pulse_input_en, .pulse_level);

// ==== testbench/trcd_contacts.sv ====
`timescale 1ns/100ps
// bank of switches, a one means closed to the common
module trcd_contacts
(
    input  wire logic       clk,
    output logic      [6:0] closed
);
    logic [6:0] want = 7'h00;
    initial closed = 7'h00;
    // contacts move just after a rising edge
    always @(posedge clk)
        closed <= want;
    task automatic set(input logic [6:0] v);
        want = v;
    endtask
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [6:0]  terminal_closed;
    logic        forward_run;
    logic        reverse_run;
    logic        output_ready;
    logic        output_cut;
    logic        coast_stop;
    logic        emergency_stop_fault;
    logic [3:0]  speed_select;
    logic        pulse_input_en;
    logic        pulse_level;
    int          num_errors = 0;
    int          num_checks = 0;
    // 200 MHz clock
    always #2.5 clk = ~clk;
    trcd_contacts trcd_contacts_inst (.clk, .closed(terminal_closed));
    trcd_top trcd_top_inst (.clk, .reset, .terminal_closed, .wb_cyc_i,
        .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .forward_run, .reverse_run, .output_ready,
        .output_cut, .coast_stop, .ramp_stop(),
        .emergency_stop_fault, .fault_reset(), .inch_run(), .inch_fwd(),
        .inch_rev(), .speed_select, .freq_up(), .freq_down(),
        .src_voltage_analog_input(), .src_current_analog_input(),
        .counter_clear(), .counter_count(), .motor_select(),
        .sequencer_select(), .nvm_write_lock(), .pulse_input_en,
        .pulse_level);
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t saw %h wanted %h", $time, seen, exp);
        end
    endtask
    // one classic cycle, held until ack
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'h3, we, 4'hF};
        wb_adr_i <= a;
        wb_dat_i <= d;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        check(n < 50, 1);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    endtask
    task automatic drive(input logic [6:0] v);
        trcd_contacts_inst.set(v);
        repeat (8) @(posedge clk);
    endtask
    task automatic t_mode1;
        logic [31:0] q;
        wb(0, trcd_pkg::REG_MODE, 0, q);
        check(q[2:0], trcd_pkg::MODE_RESET);
        drive(7'h69);
        check({forward_run, reverse_run}, 2'h2);
        check(speed_select, 4'hA);
        check({pulse_input_en, pulse_level}, 2'h3);
        drive(7'h02);
        check({forward_run, reverse_run}, 2'h1);
        $display("two wire mode 1 done");
    endtask
    task automatic t_mode2;
        logic [31:0] q;
        for (int m = 2; m <= 5; m += 3)
        begin
            wb(1, trcd_pkg::REG_MODE, m, q);
            drive(7'h01);
            check({forward_run, reverse_run}, 2'h2);
            drive(7'h03);
            check({forward_run, reverse_run}, 2'h1);
            drive(7'h02);
            check({forward_run, reverse_run}, 2'h0);
            if (m == 5)
                check(output_ready, 1);
        end
        $display("two wire mode 2 done");
    endtask
    task automatic t_mode3;
        logic [31:0] q;
        for (int m = 3; m <= 6; m += 3)
        begin
            wb(1, trcd_pkg::REG_MODE, m, q);
            drive(7'h04);
            drive(7'h05);
            drive(7'h04);
            check({forward_run, reverse_run}, 2'h2);
            check(speed_select[0], 0);
            drive(7'h06);
            check({forward_run, reverse_run}, 2'h1);
            drive(7'h02);
            check({forward_run, reverse_run}, 2'h0);
        end
        $display("three wire done");
    endtask
    task automatic t_mode0;
        logic [31:0] q;
        wb(1, trcd_pkg::REG_MODE, 0, q);
        wb(1, trcd_pkg::REG_FN_LO, {4'h0, trcd_pkg::FN_COAST,
            trcd_pkg::FN_BASE_BLOCK, trcd_pkg::FN_ESTOP,
            trcd_pkg::FN_SPEED1}, q);
        drive(7'h03);
        check({forward_run, reverse_run}, 2'h0);
        check(speed_select, 4'h1);
        check({emergency_stop_fault, output_cut, coast_stop}, 3'h4);
        drive(7'h0C);
        check({emergency_stop_fault, output_cut, coast_stop}, 3'h3);
        check(output_ready, 0);
        wb(1, trcd_pkg::REG_MODE, 1, q);
        drive(7'h01);
        check(speed_select, 4'h0);
        check({forward_run, reverse_run}, 2'h2);
        $display("mode zero done");
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        t_mode1;
        t_mode2;
        t_mode3;
        t_mode0;
        end_sim;
    end
    // watchdog
    initial
    begin
        #20000;
        num_errors++;
        end_sim;
    end
endmodule
